// ==== acc_pkg.sv ====
// Package for the comparator control block: offsets, fields, resets.
// Assumes a byte-wide register port, one clock at 20 MHz.
package acc_pkg;

  // Register offsets (byte port addresses)
  localparam logic [7:0] ACC_CSR_OFF   = 8'h28;
  localparam logic [7:0] ACC_SFIO_OFF  = 8'h20;
  localparam logic [7:0] ACC_ADC_OFF   = 8'h06;
  localparam logic [7:0] ACC_AMUX_OFF  = 8'h07;
  localparam logic [7:0] ACC_IMASK_OFF = 8'h30;
  localparam logic [7:0] ACC_ISTAT_OFF = 8'h31;

  // Control and status field positions
  localparam int ACC_OFF_BIT  = 7;
  localparam int ACC_BG_BIT   = 6;
  localparam int ACC_RES_BIT  = 5;
  localparam int ACC_FLAG_BIT = 4;
  localparam int ACC_IE_BIT   = 3;
  localparam int ACC_CAP_BIT  = 2;
  localparam int ACC_MODE_HI  = 1;
  localparam int ACC_MODE_LO  = 0;
  localparam int ACC_NME_BIT  = 3;
  localparam int ACC_CONVERTER_ENABLE_BIT = 7;
  localparam int ACC_CH_HI    = 2;

  // Reset values
  localparam logic [7:0] ACC_CSR_RST  = 8'h00;
  localparam logic [7:0] ACC_SFIO_RST = 8'h00;
  localparam logic [7:0] ACC_ADC_RST  = 8'h00;
  localparam logic [7:0] ACC_AMUX_RST = 8'h00;
  localparam logic [1:0] ACC_IRQ_RST  = 2'h0;

  // Interrupt status bits: edge event, result change
  localparam int ACC_IS_EVT = 0;
  localparam int ACC_IS_CHG = 1;

  // Edge mode encodings
  localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] ACC_MODE_RSVD   = 2'h1;
  localparam logic [1:0] ACC_MODE_FALL   = 2'h2;
  localparam logic [1:0] ACC_MODE_RISE   = 2'h3;

  // Synchroniser latency bound, in clock cycles
  localparam int ACC_SYNC_MAX_CYC = 2;

endpackage : acc_pkg

// ==== acc_sync.sv ====
// Two-flop synchroniser for the raw comparator output.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module acc_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Data
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_q;
  logic sync_q;

  // First flop feeds only the second
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : acc_sync
`default_nettype wire

// ==== acc_top.sv ====
// Comparator control: input select, result sync, edge event, capture route.
// Assumes a byte register port with read data one cycle after the strobe,
// and an analog comparator macro outside, steered by the select outputs.
// Functional notes
// (R1) Result is high when selected positive input exceeds selected negative.
// (R2) Converter channel replaces negative pin only if mux enabled and ADC off.
// (R3) Bandgap select one picks bandgap reference for positive input.
// (R4) Comparator-off bit one removes comparator power; writable any time.
// (R5) Software clears irq enable before changing comparator-off bit.
// (R6) Raw result synchronised before readable result bit; 1-2 cycles.
// (R7) Event flag sets on result change matching chosen edge mode.
// (R8) Event flag clears on vector taken or write one; zero ignored.
// (R9) Interrupt request needs flag, enable and global enable together.
// (R10) Capture route bit one feeds result to timer capture front end.
// (R11) Software sets timer capture mask to get capture interrupt.
// (R12) Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// (R13) Software clears irq enable before changing the mode field.
// (R14) Converter enable bit is one while converter is on.
// (R15) Edge detect compares synchronised result with its previous value.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module acc_top
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Analog comparator macro
  input  wire logic       comp_raw_i,
  output logic            comp_power_o,
  output logic            pos_bandgap_o,
  output logic            neg_channel_en_o,
  output logic      [2:0] neg_channel_o,
  // Converter state
  output logic            converter_on_o,
  // Core interrupt
  input  wire logic       global_irq_en_i,
  input  wire logic       vector_taken_i,
  output logic            compare_irq_o,
  // Timer capture front end
  output logic            capture_route_o,
  output logic            capture_src_o,
  // Summary interrupt
  output logic            irq_o
);

  // Control fields
  logic       comparator_off_q;
  logic       bandgap_select_q;
  logic       compare_event_flag_q;
  logic       compare_irq_enable_q;
  logic       capture_route_enable_q;
  logic [1:0] irq_mode_q;
  logic       negative_mux_enable_q;
  logic       converter_enable_q;
  logic [2:0] channel_select_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_stat_q;
  logic [7:0] rdata_q;

  // Synchronised result and its history
  logic compare_result;
  logic result_prev_q;
  logic rise;
  logic fall;
  logic edge_hit;

  // Register write strobes
  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = wr_i && (addr_i == off);
  endfunction : wr_hit

  // Does a result change match the selected edge mode
  function automatic logic mode_match(input logic [1:0] mode,
                                      input logic       r,
                                      input logic       f);
    case (mode)
      ACC_MODE_TOGGLE: mode_match = r | f;
      ACC_MODE_FALL:   mode_match = f;
      ACC_MODE_RISE:   mode_match = r;
      default:         mode_match = 1'b0; // Reserved code never fires
    endcase
  endfunction : mode_match

  // Raw comparator output into the clock domain
  acc_sync u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i (comp_raw_i),
    .sync_o  (compare_result)
  ); // R6

  // Previous synchronised value for edge detection
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_prev_q <= 1'b0;
    end else begin
      result_prev_q <= compare_result; // R15
    end
  end

  assign rise     = compare_result & ~result_prev_q; // R15
  assign fall     = ~compare_result & result_prev_q; // R15
  assign edge_hit = mode_match(irq_mode_q, rise, fall); // R7 R12

  // Control and status register fields
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      comparator_off_q       <= ACC_CSR_RST[ACC_OFF_BIT];
      bandgap_select_q       <= ACC_CSR_RST[ACC_BG_BIT];
      compare_irq_enable_q   <= ACC_CSR_RST[ACC_IE_BIT];
      capture_route_enable_q <= ACC_CSR_RST[ACC_CAP_BIT];
      irq_mode_q             <= ACC_CSR_RST[ACC_MODE_HI:ACC_MODE_LO];
    end else if (wr_hit(ACC_CSR_OFF)) begin
      comparator_off_q       <= wdata_i[ACC_OFF_BIT]; // R4
      bandgap_select_q       <= wdata_i[ACC_BG_BIT]; // R3
      compare_irq_enable_q   <= wdata_i[ACC_IE_BIT];
      capture_route_enable_q <= wdata_i[ACC_CAP_BIT]; // R10
      irq_mode_q             <= wdata_i[ACC_MODE_HI:ACC_MODE_LO];
    end
  end

  // Event flag: set beats both clears
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compare_event_flag_q <= ACC_CSR_RST[ACC_FLAG_BIT];
    end else if (edge_hit) begin
      compare_event_flag_q <= 1'b1; // R7
    end else if (vector_taken_i ||
                 (wr_hit(ACC_CSR_OFF) && wdata_i[ACC_FLAG_BIT])) begin
      compare_event_flag_q <= 1'b0; // R8
    end
  end

  // Multiplexer enable and converter control bits
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      negative_mux_enable_q <= ACC_SFIO_RST[ACC_NME_BIT];
      converter_enable_q    <= ACC_ADC_RST[ACC_CONVERTER_ENABLE_BIT];
      channel_select_q      <= ACC_AMUX_RST[ACC_CH_HI:0];
    end else begin
      if (wr_hit(ACC_SFIO_OFF)) begin
        negative_mux_enable_q <= wdata_i[ACC_NME_BIT];
      end
      if (wr_hit(ACC_ADC_OFF)) begin
        converter_enable_q <= wdata_i[ACC_CONVERTER_ENABLE_BIT]; // R14
      end
      if (wr_hit(ACC_AMUX_OFF)) begin
        channel_select_q <= wdata_i[ACC_CH_HI:0];
      end
    end
  end

  // Summary interrupt: mask and sticky status, write one to clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask_q <= ACC_IRQ_RST;
      irq_stat_q <= ACC_IRQ_RST;
    end else begin
      if (wr_hit(ACC_IMASK_OFF)) begin
        irq_mask_q <= wdata_i[1:0];
      end
      // Set wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q &
                     ~(wr_hit(ACC_ISTAT_OFF) ? wdata_i[1:0] : 2'h0)) |
                    {rise | fall, edge_hit};
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == ACC_CSR_OFF) begin
        rdata_q <= {comparator_off_q, bandgap_select_q, compare_result,
                    compare_event_flag_q, compare_irq_enable_q,
                    capture_route_enable_q, irq_mode_q}; // R6
      end else if (addr_i == ACC_SFIO_OFF) begin
        rdata_q <= {4'h0, negative_mux_enable_q, 3'h0};
      end else if (addr_i == ACC_ADC_OFF) begin
        rdata_q <= {converter_enable_q, 7'h00};
      end else if (addr_i == ACC_AMUX_OFF) begin
        rdata_q <= {5'h00, channel_select_q};
      end else if (addr_i == ACC_IMASK_OFF) begin
        rdata_q <= {6'h00, irq_mask_q};
      end else if (addr_i == ACC_ISTAT_OFF) begin
        rdata_q <= {6'h00, irq_stat_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o = rdata_q;

  // Analog steering; the macro itself does the comparison
  assign comp_power_o     = ~comparator_off_q; // R4 R1
  assign pos_bandgap_o    = bandgap_select_q; // R3
  assign neg_channel_en_o = negative_mux_enable_q & ~converter_enable_q; // R2
  assign neg_channel_o    = channel_select_q; // R2
  assign converter_on_o   = converter_enable_q; // R14

  // Core request; software owns enable sequencing around mode changes
  assign compare_irq_o = compare_event_flag_q & compare_irq_enable_q &
                         global_irq_en_i; // R9

  // Capture route: gated so no path exists while disabled
  assign capture_route_o = capture_route_enable_q; // R10
  assign capture_src_o   = compare_result & capture_route_enable_q; // R10

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Assertions
  a_irq_needs_all: // R9
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    compare_irq_o |-> (compare_event_flag_q && compare_irq_enable_q &&
                       global_irq_en_i))
    else $error("compare irq without flag and enables");

  a_irq_when_all: // R9
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (compare_event_flag_q && compare_irq_enable_q && global_irq_en_i)
      |-> compare_irq_o)
    else $error("compare irq missing");

  a_flag_on_rise: // R7
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (irq_mode_q == ACC_MODE_RISE && !result_prev_q && compare_result)
      |=> compare_event_flag_q)
    else $error("rising edge did not set flag");

  a_flag_on_fall: // R12
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (irq_mode_q == ACC_MODE_FALL && $fell(compare_result))
      |=> compare_event_flag_q)
    else $error("falling edge did not set flag");

  a_rsvd_no_set: // R12
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (irq_mode_q == ACC_MODE_RSVD && !compare_event_flag_q)
      |=> !compare_event_flag_q)
    else $error("reserved mode set flag");

  a_flag_clear_vec: // R8
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (vector_taken_i && !edge_hit) |=> !compare_event_flag_q)
    else $error("vector did not clear flag");

  a_flag_write_zero: // R8
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (compare_event_flag_q && !vector_taken_i && wr_hit(ACC_CSR_OFF) &&
     !wdata_i[ACC_FLAG_BIT]) |=> compare_event_flag_q)
    else $error("writing zero cleared flag");

  a_sync_latency: // R6
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (comp_raw_i && $past(comp_raw_i)) |=> compare_result)
    else $error("result not synchronised in two cycles");

  a_neg_mux_sel: // R2
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    neg_channel_en_o |-> (negative_mux_enable_q && !converter_enable_q))
    else $error("channel used while converter on");

  a_capture_gate: // R10
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !capture_route_enable_q |-> !capture_src_o)
    else $error("capture fed while route off");

  a_power_off: // R4
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_hit(ACC_CSR_OFF) && wdata_i[ACC_OFF_BIT]) |=> !comp_power_o)
    else $error("comparator still powered");

  // Synchroniser and edge history; a low raw level needs two edges too
  a_sync_fall: // R6
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!comp_raw_i && !$past(comp_raw_i)) |=> !compare_result)
    else $error("low result not synchronised in two cycles");

  a_prev_tracks: // R15
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    result_prev_q == $past(compare_result))
    else $error("edge history lags the synchronised result");

  // Event flag set and clear paths
  a_flag_on_toggle: // R7 R12
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (irq_mode_q == ACC_MODE_TOGGLE && (compare_result != result_prev_q))
      |=> compare_event_flag_q)
    else $error("toggle did not set flag");

  a_flag_needs_edge: // R7
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!compare_event_flag_q && !edge_hit) |=> !compare_event_flag_q)
    else $error("flag set without a matching edge");

  a_flag_write_one: // R8
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_hit(ACC_CSR_OFF) && wdata_i[ACC_FLAG_BIT] && !edge_hit)
      |=> !compare_event_flag_q)
    else $error("writing one did not clear flag");

  // Register port: data stand only after a read strobe
  a_rdata_idle_zero:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !rd_i |=> (rdata_o == 8'h00))
    else $error("read data without a read strobe");

  a_result_readback: // R6
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rd_i && addr_i == ACC_CSR_OFF)
      |=> (rdata_o[ACC_RES_BIT] == $past(compare_result)))
    else $error("result bit readback wrong");

  // Analog steering follows the control writes
  a_bandgap_write: // R3
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_hit(ACC_CSR_OFF) |=> (pos_bandgap_o == $past(wdata_i[ACC_BG_BIT])))
    else $error("bandgap select does not follow write");

  a_power_on: // R4
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_hit(ACC_CSR_OFF) && !wdata_i[ACC_OFF_BIT]) |=> comp_power_o)
    else $error("comparator not powered after enable");

  a_chan_used: // R2
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (negative_mux_enable_q && !converter_enable_q)
      |-> (neg_channel_en_o && (neg_channel_o == channel_select_q)))
    else $error("channel not used while mux on and converter off");

  a_conv_on_write: // R14
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_hit(ACC_ADC_OFF)
      |=> (converter_on_o == $past(wdata_i[ACC_CONVERTER_ENABLE_BIT])))
    else $error("converter enable does not follow write");

  // Capture route and summary status
  a_capture_follow: // R10
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    capture_route_enable_q |-> (capture_src_o == compare_result))
    else $error("capture source does not follow result");

  a_stat_set_wins:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (edge_hit && wr_hit(ACC_ISTAT_OFF) && wdata_i[ACC_IS_EVT])
      |=> irq_stat_q[ACC_IS_EVT])
    else $error("status clear beat a new event");

endmodule : acc_top
`default_nettype wire

// ==== acc_tb.sv ====
// Self-checking bench for the comparator control block.
// Assumes acc_pkg and acc_top are compiled first; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb
  import acc_pkg::*;
;
  logic       clk_i, rst_b_i, wr_i, rd_i, comp_raw_i;
  logic       global_irq_en_i, vector_taken_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic       comp_power_o, pos_bandgap_o, neg_channel_en_o, converter_on_o;
  logic       compare_irq_o, capture_route_o, capture_src_o, irq_o;
  logic [2:0] neg_channel_o;
  int         n_errors, compares, cyc;

  acc_top DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .comp_raw_i(comp_raw_i),
    .comp_power_o(comp_power_o), .pos_bandgap_o(pos_bandgap_o),
    .neg_channel_en_o(neg_channel_en_o), .neg_channel_o(neg_channel_o),
    .converter_on_o(converter_on_o), .global_irq_en_i(global_irq_en_i),
    .vector_taken_i(vector_taken_i), .compare_irq_o(compare_irq_o),
    .capture_route_o(capture_route_o), .capture_src_o(capture_src_o),
    .irq_o(irq_o)
  );

  // Free-running 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Hang guard: run needs a few hundred cycles at most
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk1(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h", $time, m, got);
    end
  endtask : chk8

  // One-cycle write strobe; outputs settle just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input string m);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk8(rdata_o, e, m);
  endtask : rdchk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_cyc

  task automatic t_reset();
    rdchk(ACC_CSR_OFF, ACC_CSR_RST, "csr reset");
    chk1(comp_power_o, 1'b1, "power at reset");
    rdchk(8'hff, 8'h00, "unmapped read");
  endtask : t_reset

  task automatic t_select();
    wr(ACC_CSR_OFF, 8'hc4);
    chk1(comp_power_o, 1'b0, "power off");
    chk1(pos_bandgap_o, 1'b1, "bandgap on");
    chk1(capture_route_o, 1'b1, "route on");
    rdchk(ACC_CSR_OFF, 8'hc4, "csr readback");
    wr(ACC_CSR_OFF, 8'h00);
    chk1(pos_bandgap_o, 1'b0, "bandgap off");
    chk1(capture_route_o, 1'b0, "route off");
    wr(ACC_SFIO_OFF, 8'h08);
    wr(ACC_AMUX_OFF, 8'h05);
    chk1(neg_channel_en_o, 1'b1, "channel in use");
    chk8({5'h00, neg_channel_o}, 8'h05, "channel number");
    wr(ACC_ADC_OFF, 8'h80);
    chk1(converter_on_o, 1'b1, "converter on");
    chk1(neg_channel_en_o, 1'b0, "pin while conv on");
    wr(ACC_ADC_OFF, 8'h00);
    wr(ACC_SFIO_OFF, 8'h00);
    chk1(neg_channel_en_o, 1'b0, "pin while mux off");
  endtask : t_select

  // Every mode against both edges; result toggles each step
  task automatic t_events();
    logic [15:0] md;
    logic [7:0]  ex;
    logic [1:0]  m;
    logic        r;
    md = 16'h5fa0;
    ex = 8'h1b;
    for (int i = 0; i < 8; i++) begin
      m = md[2*i+:2];
      r = ~i[0];
      wr(ACC_CSR_OFF, {4'h1, 2'b00, m});
      @(posedge clk_i);
      comp_raw_i <= r;
      wait_cyc(4);
      rdchk(ACC_CSR_OFF, {2'b00, r, ex[i], 2'b00, m}, "edge mode");
    end
  endtask : t_events

  task automatic t_irq();
    wr(ACC_CSR_OFF, 8'h1c);
    @(posedge clk_i);
    comp_raw_i <= 1'b1;
    wait_cyc(2);
    chk1(capture_src_o, 1'b1, "capture source");
    wait_cyc(2);
    chk1(compare_irq_o, 1'b0, "no global enable");
    chk1(irq_o, 1'b0, "summary masked");
    @(posedge clk_i);
    global_irq_en_i <= 1'b1;
    #1;
    chk1(compare_irq_o, 1'b1, "irq request");
    wr(ACC_IMASK_OFF, 8'h01);
    chk1(irq_o, 1'b1, "summary raised");
    rdchk(ACC_IMASK_OFF, 8'h01, "mask readback");
    wr(ACC_ISTAT_OFF, 8'h03);
    chk1(irq_o, 1'b0, "summary cleared");
    wr(ACC_CSR_OFF, 8'h0c);
    chk1(compare_irq_o, 1'b1, "write zero keeps");
    wr(ACC_CSR_OFF, 8'h04);
    chk1(compare_irq_o, 1'b0, "enable off");
    wr(ACC_CSR_OFF, 8'h0c);
    @(posedge clk_i);
    vector_taken_i <= 1'b1;
    @(posedge clk_i);
    vector_taken_i <= 1'b0;
    #1;
    chk1(compare_irq_o, 1'b0, "vector clears");
    @(posedge clk_i);
    comp_raw_i <= 1'b0;
    wait_cyc(4);
    chk1(compare_irq_o, 1'b1, "falling toggle");
    wr(ACC_CSR_OFF, 8'h1c);
    chk1(compare_irq_o, 1'b0, "write one clears");
    wr(ACC_CSR_OFF, 8'h00);
  endtask : t_irq

  // Main sequence: quiet inputs, reset for 3 cycles, then scenarios
  initial begin
    {wr_i, rd_i, comp_raw_i, global_irq_en_i, vector_taken_i} = 5'h00;
    addr_i   = 8'h00;
    wdata_i  = 8'h00;
    rst_b_i  = 1'b0;
    n_errors = 0;
    compares = 0;
    cyc      = 0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_select();
    t_events();
    t_irq();
    end_sim();
  end
endmodule : tb
`default_nettype wire
